/* File: inc/spc_defines.vh */
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// ==========================================
// clock and timing
`define SPC_CLK_KHZ 40000
`define SPC_DEB_MS 20
`define SPC_DEB_CYC (`SPC_DEB_MS * `SPC_CLK_KHZ)
`define SPC_KNOB_MS 1
`define SPC_KNOB_CYC (`SPC_KNOB_MS * `SPC_CLK_KHZ)
`define SPC_HOLD_S 3
`define SPC_HOLD_CYC (`SPC_HOLD_S * `SPC_CLK_KHZ * 1000)
`define SPC_RST_NS 1000
`define SPC_RST_CYC ((`SPC_RST_NS * `SPC_CLK_KHZ + 999999) / 1000000)

// ==========================================
// register offsets (word index on the plain port)
`define SPC_ADDR_CTRL 2'h0
`define SPC_ADDR_VOL 2'h1
`define SPC_ADDR_STAT 2'h2

// ==========================================
// control register fields
`define SPC_CTRL_MODE_LSB 0
`define SPC_CTRL_MODE_MSB 1
`define SPC_CTRL_PROC_BIT 4

// ==========================================
// status register fields
`define SPC_STAT_MUTE_BIT 0
`define SPC_STAT_SRC_BIT 1
`define SPC_STAT_COAX_BIT 2
`define SPC_STAT_VALID_BIT 3
`define SPC_STAT_RST_BIT 4

// ==========================================
// preset modes
`define SPC_MODE_ANALOG 2'h0
`define SPC_MODE_OPTICAL 2'h1
`define SPC_MODE_COAX 2'h2
`define SPC_MODE_AUTO 2'h3

// ==========================================
// volume codes: attenuation in 0.5 dB steps
`define SPC_VOL_M20DB 8'h28
`define SPC_VOL_MAX 8'hFF
`define SPC_VOL_MIN 8'h00

// ==========================================
// reset values
`define SPC_MODE_RST `SPC_MODE_AUTO

`endif

/* File: core/spc_debounce.v */
`timescale 1ns/1ps
// ==========================================
// debounce of one panel input
module spc_debounce #(
  parameter [31:0] CYC = 32'd40000
) (
  input wire core_clk,
  input wire srst,
  input wire raw,
  output reg clean_reg,
  output reg rise_reg,
  output reg fall_reg
);

  reg [31:0] cnt_reg; // cycles that raw differs from clean

  // ==========================================
  // accept a new level only once it stood CYC cycles
  always @(posedge core_clk) begin
    if (srst) begin
      cnt_reg <= 32'h0;
      clean_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      if (raw == clean_reg) begin
        // stable, restart the count
        cnt_reg <= 32'h0;
      end else if (cnt_reg >= CYC - 32'd1) begin
        // level held long enough, take it
        cnt_reg <= 32'h0;
        clean_reg <= raw;
        rise_reg <= raw;
        fall_reg <= ~raw;
      end else begin
        cnt_reg <= cnt_reg + 32'd1;
      end
    end
  end

endmodule // spc_debounce

/* File: core/spc_panel.v */
`timescale 1ns/1ps
`include "spc_defines.vh"
// ==========================================
// stand-alone front panel controller
// reads the mute and reset buttons and the volume knob
// and drives the amplifier and receiver control lines
// with no host attached
// - every panel input passes a debouncer first
// - a tap of mute toggles mute once it is released
// - a long hold of mute swaps the receiver input instead
// - each knob detent steps the volume by one code
// - the board reset restarts the panel and every device
// - devices stay in reset for a stretch after release
// - software may load a preset through the ctrl register
// hazard: a toggle at press would fire on every long hold,
// so the toggle waits for the release
// hazard: writes that land during a restart are dropped
// limitation: hold time counts from the clean press
// limitation: volume saturates at both ends of the code
// limitation: knob steps need a clean a edge per detent
module spc_panel #(
  parameter [31:0] DEB_CYC = `SPC_DEB_CYC,
  parameter [31:0] KNOB_CYC = `SPC_KNOB_CYC,
  parameter [31:0] HOLD_CYC = `SPC_HOLD_CYC
) (
  input wire core_clk,
  input wire srst,
  input wire mute_btn_n,
  input wire rst_btn_n,
  input wire knob_a,
  input wire knob_b,
  input wire spdif_valid,
  input wire [1:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  output reg amp_mute,
  output reg amp_src_spdif,
  output reg amp_proc_en,
  output reg [7:0] amp_vol,
  output reg amp_vol_wr,
  output reg rx_sel_coax,
  output reg dev_rst_n
);

  // ==========================================
  // local constants
  // the stretch count is formed at full width, then narrowed
  localparam [31:0] RST_CYC_W = `SPC_RST_CYC; // stretch, full width
  localparam [7:0] RST_CYC = RST_CYC_W[7:0]; // device reset stretch

  // ==========================================
  // debounced panel signals
  // all of these come from flops inside the debouncers,
  // so no raw contact bounce reaches the state logic
  wire mute_pressed; // mute button held, clean
  wire mute_press; // pulse at clean press
  wire mute_release; // pulse at clean release
  wire rst_pressed; // board reset held, clean
  wire knob_a_clean; // encoder phase a, clean
  wire knob_a_rise; // encoder detent edge
  wire knob_b_clean; // encoder phase b, clean

  // ==========================================
  // controller state
  // each register pairs with its next value below;
  // the output flops copy the next values directly
  reg [1:0] mode_reg; // preset mode
  reg [1:0] mode_next;
  reg mute_reg; // mute state
  reg mute_next;
  reg coax_reg; // receiver input: 1 coaxial
  reg coax_next;
  reg proc_reg; // amplifier processing enable
  reg proc_next;
  reg [7:0] vol_reg; // volume code
  reg [7:0] vol_next;
  reg vol_wr_next; // volume write request
  reg src_next; // amplifier source: 1 s/pdif
  reg [31:0] hold_reg; // mute hold length counter
  reg [31:0] hold_next;
  reg held_reg; // current press became a long hold
  reg held_next;
  reg [7:0] rst_cnt_reg; // device reset stretch counter
  reg [7:0] rst_cnt_next;
  reg [7:0] rdata_next; // read mux
  reg rst_all; // controller and devices restart

  // ==========================================
  // button and knob debouncers
  // buttons are active low at the pin, inverted here so
  // that a clean level of one means pressed
  // the knob phases use a shorter settle time
  spc_debounce #(
    .CYC(DEB_CYC)
  ) u_mute_deb (
    .core_clk(core_clk),
    .srst(srst),
    .raw(~mute_btn_n),
    .clean_reg(mute_pressed),
    .rise_reg(mute_press),
    .fall_reg(mute_release)
  );

  spc_debounce #(
    .CYC(DEB_CYC)
  ) u_rst_deb (
    .core_clk(core_clk),
    .srst(srst),
    .raw(~rst_btn_n),
    .clean_reg(rst_pressed),
    .rise_reg(),
    .fall_reg()
  );

  spc_debounce #(
    .CYC(KNOB_CYC)
  ) u_knob_a_deb (
    .core_clk(core_clk),
    .srst(srst),
    .raw(knob_a),
    .clean_reg(knob_a_clean),
    .rise_reg(knob_a_rise),
    .fall_reg()
  );

  spc_debounce #(
    .CYC(KNOB_CYC)
  ) u_knob_b_deb (
    .core_clk(core_clk),
    .srst(srst),
    .raw(knob_b),
    .clean_reg(knob_b_clean),
    .rise_reg(),
    .fall_reg()
  );

  // ==========================================
  // next-state logic
  always @* begin
    mode_next = mode_reg;
    mute_next = mute_reg;
    coax_next = coax_reg;
    proc_next = proc_reg;
    vol_next = vol_reg;
    vol_wr_next = 1'b0;
    hold_next = hold_reg;
    held_next = held_reg;
    rst_cnt_next = rst_cnt_reg;
    rst_all = srst | rst_pressed;

    // restart: reset line and stretch counter
    // the counter reloads on every restart cycle, so the
    // stretch is always measured from the last one
    // a held board reset keeps the devices down throughout
    if (rst_all) begin
      rst_cnt_next = RST_CYC;
    end else if (rst_cnt_reg != 8'h00) begin
      rst_cnt_next = rst_cnt_reg - 8'h01;
    end

    if (rst_all) begin
      // restart loads the stand-alone preset
      mode_next = `SPC_MODE_RST;
      mute_next = 1'b0;
      coax_next = 1'b0;
      proc_next = 1'b0;
      vol_next = `SPC_VOL_M20DB;
      vol_wr_next = 1'b1;
      hold_next = 32'h0;
      held_next = 1'b0;
    end else if (bus_wr && bus_addr == `SPC_ADDR_CTRL) begin
      // software preset load
      mode_next = bus_wdata[`SPC_CTRL_MODE_MSB:`SPC_CTRL_MODE_LSB];
      mute_next = 1'b0;
      proc_next = bus_wdata[`SPC_CTRL_PROC_BIT];
      vol_next = `SPC_VOL_M20DB;
      vol_wr_next = 1'b1;
      case (bus_wdata[`SPC_CTRL_MODE_MSB:`SPC_CTRL_MODE_LSB])
        `SPC_MODE_OPTICAL: begin
          coax_next = 1'b0;
        end
        `SPC_MODE_COAX: begin
          coax_next = 1'b1;
        end
        default: begin
          // analog and auto keep the input choice
          coax_next = coax_reg;
        end
      endcase
    end else begin
      // software volume write
      if (bus_wr && bus_addr == `SPC_ADDR_VOL) begin
        vol_next = bus_wdata;
        vol_wr_next = 1'b1;
      end else if (knob_a_rise) begin
        // knob detent: b low is clockwise, louder
        if (!knob_b_clean) begin
          if (vol_reg != `SPC_VOL_MIN) begin
            vol_next = vol_reg - 8'h01;
            vol_wr_next = 1'b1;
          end
        end else begin
          if (vol_reg != `SPC_VOL_MAX) begin
            vol_next = vol_reg + 8'h01;
            vol_wr_next = 1'b1;
          end
        end
      end

      // mute button: tap or long hold
      // the counter restarts at every clean press and stops
      // once the hold has fired, so one hold swaps only once
      // held_reg remembers the hold until the next press,
      // which keeps the later release from toggling mute
      if (mute_press) begin
        hold_next = 32'h0;
        held_next = 1'b0;
      end else if (mute_pressed && !held_reg) begin
        if (hold_reg >= HOLD_CYC - 32'd1) begin
          // three seconds held: swap receiver input
          coax_next = ~coax_reg;
          held_next = 1'b1;
          hold_next = 32'h0;
        end else begin
          hold_next = hold_reg + 32'd1;
        end
      end

      // short tap toggles mute at release
      // mute keeps the pwm switching at even duty, so there
      // is no pop from stopping and restarting the outputs
      if (mute_release && !held_reg) begin
        mute_next = ~mute_reg;
      end
    end

    // source follows mode and s/pdif lock
    // decoded from the next mode, so a preset load and its
    // source change reach the pins in the same cycle
    case (mode_next)
      `SPC_MODE_ANALOG: begin
        src_next = 1'b0;
      end
      `SPC_MODE_OPTICAL: begin
        src_next = 1'b1;
      end
      `SPC_MODE_COAX: begin
        src_next = 1'b1;
      end
      default: begin
        // stand-alone: pick by lock indication
        src_next = spdif_valid;
      end
    endcase

    // read mux, data stand one cycle only
    // idle cycles drive zero, so stale data never linger
    // on the read port between two reads
    rdata_next = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        `SPC_ADDR_CTRL: begin
          rdata_next[`SPC_CTRL_MODE_MSB:`SPC_CTRL_MODE_LSB] = mode_reg;
          rdata_next[`SPC_CTRL_PROC_BIT] = proc_reg;
        end
        `SPC_ADDR_VOL: begin
          rdata_next = vol_reg;
        end
        `SPC_ADDR_STAT: begin
          rdata_next[`SPC_STAT_MUTE_BIT] = mute_reg;
          rdata_next[`SPC_STAT_SRC_BIT] = amp_src_spdif;
          rdata_next[`SPC_STAT_COAX_BIT] = coax_reg;
          rdata_next[`SPC_STAT_VALID_BIT] = spdif_valid;
          rdata_next[`SPC_STAT_RST_BIT] = ~dev_rst_n;
        end
        default: begin
          // unmapped reads as zero
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // ==========================================
  // state registers
  // reset values match the stand-alone preset that a
  // restart loads, so both paths leave the same state
  // the stretch counter starts full so devices wait too
  always @(posedge core_clk) begin
    if (srst) begin
      mode_reg <= `SPC_MODE_RST;
      mute_reg <= 1'b0;
      coax_reg <= 1'b0;
      proc_reg <= 1'b0;
      vol_reg <= `SPC_VOL_M20DB;
      hold_reg <= 32'h0;
      held_reg <= 1'b0;
      rst_cnt_reg <= RST_CYC;
    end else begin
      mode_reg <= mode_next;
      mute_reg <= mute_next;
      coax_reg <= coax_next;
      proc_reg <= proc_next;
      vol_reg <= vol_next;
      hold_reg <= hold_next;
      held_reg <= held_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // ==========================================
  // output flops towards amplifier and receiver
  // every pin comes straight from a flop fed by the next
  // values, so outputs move one cycle after their cause
  // and never glitch between clock edges
  always @(posedge core_clk) begin
    if (srst) begin
      amp_mute <= 1'b0;
      amp_src_spdif <= 1'b0;
      amp_proc_en <= 1'b0;
      amp_vol <= `SPC_VOL_M20DB;
      amp_vol_wr <= 1'b0;
      rx_sel_coax <= 1'b0;
      dev_rst_n <= 1'b0;
      bus_rdata <= 8'h00;
    end else begin
      // mute holds pwm at 50/50 duty, switching kept
      amp_mute <= mute_next;
      amp_src_spdif <= src_next;
      amp_proc_en <= proc_next;
      amp_vol <= vol_next;
      amp_vol_wr <= vol_wr_next;
      rx_sel_coax <= coax_next;
      // every device held in reset with the panel
      dev_rst_n <= ~(rst_all | (rst_cnt_next != 8'h00));
      bus_rdata <= rdata_next;
    end
  end

endmodule // spc_panel

/* File: sim/spc_panel_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// port checker of the panel controller
module spc_panel_chk #(
  parameter [31:0] DEB_CYC = 32'd8,
  parameter [31:0] KNOB_CYC = 32'd4,
  parameter [31:0] HOLD_CYC = 32'd50
) (
  input wire core_clk,
  input wire srst,
  input wire mute_btn_n,
  input wire rst_btn_n,
  input wire spdif_valid,
  input wire [1:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire amp_mute,
  input wire amp_src_spdif,
  input wire amp_proc_en,
  input wire [7:0] amp_vol,
  input wire amp_vol_wr,
  input wire rx_sel_coax,
  input wire dev_rst_n
);
  reg [1:0] mode_reg; // preset mode last written
  reg mode_ok; // mode_reg known to mirror the design
  wire ctrl_wr = bus_wr && bus_addr == 2'h0 && dev_rst_n;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ==========================================
  // mode tracking
  always @(posedge core_clk) begin
    if (srst) begin
      mode_reg <= 2'h3;
      mode_ok <= 1'b1;
    end else if (bus_wr && bus_addr == 2'h0) begin
      // a write while devices sit in reset may be dropped
      mode_reg <= bus_wdata[1:0];
      mode_ok <= dev_rst_n;
    end else if ($fell(dev_rst_n)) begin
      // a restart reloads the stand-alone mode
      mode_reg <= 2'h3;
      mode_ok <= 1'b1;
    end
  end
  // ==========================================
  // assertions
  AST_SRC_AUTO:
    assert property (mode_reg == 2'h3 && mode_ok && dev_rst_n && !bus_wr
      |=> amp_src_spdif == $past(spdif_valid)) else $error("bad source");
  AST_SRC_FIXED:
    assert property (mode_reg != 2'h3 && mode_ok && dev_rst_n &&
      !$past(bus_wr) |-> amp_src_spdif == (mode_reg != 2'h0))
      else $error("bad preset");
  AST_VOL_WR:
    assert property (bus_wr && bus_addr == 2'h1 && dev_rst_n
      |=> amp_vol_wr && amp_vol == $past(bus_wdata)) else $error("bad vol");
  AST_PRESET:
    assert property (ctrl_wr |=> amp_vol_wr && amp_vol == 8'h28 &&
      !amp_mute && amp_proc_en == $past(bus_wdata[4])) else $error("bad load");
  AST_RX_SEL:
    assert property (ctrl_wr && bus_wdata[1] != bus_wdata[0]
      |=> rx_sel_coax == $past(bus_wdata[1])) else $error("bad input");
  AST_RST_LOW:
    assert property ($fell(srst) |-> !dev_rst_n [*8]) else $error("no hold");
  AST_RST_RISE:
    assert property ($fell(srst) |-> ##[39:42] dev_rst_n) else $error("stuck");
  AST_RST_BTN:
    assert property (!rst_btn_n [*8] ##1 !rst_btn_n [*4] |-> !dev_rst_n)
      else $error("button ignored");
  AST_MUTE_CAUSE:
    assert property ($changed(amp_mute) && !$past(bus_wr) && dev_rst_n &&
      $past(dev_rst_n) |-> $past(mute_btn_n)) else $error("mute while held");
  AST_SWAP_CAUSE:
    assert property ($changed(rx_sel_coax) && !$past(bus_wr) &&
      dev_rst_n && $past(dev_rst_n) |-> !$past(mute_btn_n))
      else $error("bad swap");
endmodule // spc_panel_chk
bind spc_panel spc_panel_chk #(.DEB_CYC(DEB_CYC), .KNOB_CYC(KNOB_CYC),
  .HOLD_CYC(HOLD_CYC)) u_chk (.core_clk(core_clk), .srst(srst),
  .mute_btn_n(mute_btn_n), .rst_btn_n(rst_btn_n), .spdif_valid(spdif_valid),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .amp_mute(amp_mute), .amp_src_spdif(amp_src_spdif),
  .amp_proc_en(amp_proc_en), .amp_vol(amp_vol), .amp_vol_wr(amp_vol_wr),
  .rx_sel_coax(rx_sel_coax), .dev_rst_n(dev_rst_n));

/* File: sim/spc_far_model.sv */
`timescale 1ns/1ps
// ==========================================
// far side: chattering contacts, knob, receiver lock
module spc_far_model (
  input wire core_clk,
  input wire mute_press,
  input wire rst_press,
  input wire ka_req,
  input wire kb_req,
  input wire lock_req,
  output reg mute_btn_n,
  output reg rst_btn_n,
  output reg knob_a,
  output reg knob_b,
  output reg spdif_valid
);
  reg [1:0] bm, br; // chatter counters
  reg lm, lr; // last requested levels
  initial begin
    {bm, br, lm, lr, knob_a, knob_b, spdif_valid} = 9'h000;
    {mute_btn_n, rst_btn_n} = 2'h3;
  end
  // contacts chatter for three cycles after each change
  always @(posedge core_clk) begin
    lm <= mute_press;
    lr <= rst_press;
    bm <= (mute_press != lm) ? 2'h3 : bm - {1'b0, bm != 2'h0};
    br <= (rst_press != lr) ? 2'h3 : br - {1'b0, br != 2'h0};
    mute_btn_n <= ~mute_press ^ bm[0];
    rst_btn_n <= ~rst_press ^ br[0];
    knob_a <= ka_req;
    knob_b <= kb_req;
    spdif_valid <= lock_req;
  end
endmodule // spc_far_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
// ==========================================
// self-checking bench of the panel controller
module tb;
  reg core_clk, srst, bus_wr, bus_rd, rd_q, mp, rp, ka, kb, lock, em, ec;
  reg [1:0] bus_addr;
  reg [7:0] bus_wdata, ve;
  reg [31:0] rn; // raw random word
  wire mbn, rbn, kna, knb, sv, amp_mute, amp_src_spdif, amp_vol_wr, dev_rst_n;
  wire [7:0] bus_rdata, amp_vol;
  integer errors, n_checks, i, sd;
  reg [7:0] q_rd[$], q_vol[$];
  spc_far_model u_far (.core_clk(core_clk), .mute_press(mp), .rst_press(rp),
    .ka_req(ka), .kb_req(kb), .lock_req(lock), .mute_btn_n(mbn),
    .rst_btn_n(rbn), .knob_a(kna), .knob_b(knb), .spdif_valid(sv));
  spc_panel #(.DEB_CYC(32'd8), .KNOB_CYC(32'd4), .HOLD_CYC(32'd50)) DUT (
    .core_clk(core_clk), .srst(srst), .mute_btn_n(mbn), .rst_btn_n(rbn),
    .knob_a(kna), .knob_b(knb), .spdif_valid(sv), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .amp_mute(amp_mute), .amp_src_spdif(amp_src_spdif),
    .amp_proc_en(), .amp_vol(amp_vol), .amp_vol_wr(amp_vol_wr),
    .rx_sel_coax(), .dev_rst_n(dev_rst_n));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // one-cycle bus write and read
  task wr(input [1:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge core_clk);
      bus_wr <= 1'b0;
    end
  endtask
  task rd(input [1:0] a, input [7:0] e);
    begin
      q_rd.push_back(e);
      @(posedge core_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge core_clk);
      bus_rd <= 1'b0;
    end
  endtask
  // expected status byte
  function [7:0] st(input s, input r);
    st = {3'h0, r, lock, ec, s, em};
  endfunction
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // result watcher: oldest note against what appears
  always @(posedge core_clk) begin
    rd_q <= bus_rd;
    if (rd_q) check(bus_rdata, q_rd.pop_front());
    if (amp_vol_wr && dev_rst_n)
      check(amp_vol, q_vol.size() > 0 ? q_vol.pop_front() : 8'hXX);
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    {srst, bus_wr, bus_rd, mp, rp, ka, kb, lock, em, ec} = 10'h200;
    {bus_addr, bus_wdata, errors, n_checks} = 0;
    sd = $urandom(32'h132E);
    cyc(12);
    srst <= 1'b0;
    rd(2'h2, st(0, 1));
    cyc(45);
    rd(2'h2, st(0, 0));
    lock <= 1'b1;
    cyc(4);
    rd(2'h2, st(1, 0));
    rn = $urandom;
    ve = rn[7:0];
    q_vol.push_back(ve);
    wr(2'h1, ve);
    wr(2'h2, 8'hFF);
    wr(2'h3, 8'hFF);
    rd(2'h1, ve);
    rd(2'h3, 8'h00);
    rd(2'h2, st(1, 0));
    for (i = 0; i < 4; i = i + 1) begin
      rn = $urandom;
      q_vol.push_back(8'h28);
      wr(2'h0, {3'h0, rn[4], 2'h0, i[1:0]});
      if (i == 1 || i == 2) ec = (i == 2);
      rd(2'h0, {3'h0, rn[4], 2'h0, i[1:0]});
      rd(2'h2, st(i != 0, 0));
    end
    for (i = 0; i < 3; i = i + 1) begin
      mp <= 1'b1;
      cyc(i == 2 ? 3 : 20);
      mp <= 1'b0;
      cyc(20);
      em = (i == 2) ? em : ~em;
      rd(2'h2, st(1, 0));
    end
    mp <= 1'b1;
    cyc(80);
    ec = ~ec;
    rd(2'h2, st(1, 0));
    mp <= 1'b0;
    cyc(20);
    rd(2'h2, st(1, 0));
    ve = 8'h28; // preset loads left the volume here
    for (i = 0; i < 8; i = i + 1) begin
      rn = $urandom;
      kb <= rn[0];
      cyc(2);
      ka <= 1'b1;
      ve = rn[0] ? ve + 8'h01 : ve - 8'h01;
      q_vol.push_back(ve);
      cyc(9);
      ka <= 1'b0;
      cyc(9);
    end
    rp <= 1'b1;
    cyc(20);
    wr(2'h1, 8'h11);
    rd(2'h2, st(1, 1));
    rp <= 1'b0;
    cyc(60);
    rd(2'h1, 8'h28);
    lock <= 1'b0;
    cyc(4);
    rd(2'h2, st(0, 0));
    cyc(4);
    give_verdict;
  end
endmodule // tb
